// file: wdt_cfg.svh
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// register byte addresses on the avalon bus
`define WDT_ADDR_LOAD     32'hFFFF0360
`define WDT_ADDR_COUNT    32'hFFFF0364
`define WDT_ADDR_CTRL     32'hFFFF0368
`define WDT_ADDR_SVC      32'hFFFF036C
`define WDT_ADDR_CAP      32'hFFFF0370

// reset values
`define WDT_LOAD_RST      16'h03D7
`define WDT_COUNT_RST     16'h03D7
`define WDT_CTRL_RST      16'h0000
`define WDT_CAP_RST       16'h0000
`define WDT_RDATA_RST     32'h00000000

// writable control bits; bits 15:9 read as zero
`define WDT_CTRL_MASK     16'h01FF

// counter end points
`define WDT_CNT_MAX       16'hFFFF
`define WDT_CNT_ZERO      16'h0000
`define WDT_CNT_STEP      16'h0001
`define WDT_HI_ZERO       16'h0000

// control field positions
`define WDT_B_PDOFF       0
`define WDT_B_IRQSEL      1
`define WDT_B_PSC_LO      2
`define WDT_B_PSC_HI      3
`define WDT_B_SECURE      4
`define WDT_B_WDOG        5
`define WDT_B_PERIODIC    6
`define WDT_B_EN          7
`define WDT_B_UP          8

// prescaler select codes and divider masks
`define WDT_PSC_DIV1      2'h0
`define WDT_PSC_DIV16     2'h1
`define WDT_PSC_DIV256    2'h2
`define WDT_PSC_M16       4'hF
`define WDT_PSC_M256      8'hFF
`define WDT_PSC_STEP      8'h01
`define WDT_PSC_RST       8'h00

// timebase figures: 65536 ticks at 32768/256 Hz give 512 s
`define WDT_OSC_HZ        32768
`define WDT_MAX_TIMEOUT_S 512

`endif

// file: wdt_pkg.sv
package wdt_pkg;
  // bus word and register word
  typedef logic [31:0] wdt_data_t;
  typedef logic [15:0] wdt_word_t;
  typedef logic [3:0]  wdt_be_t;
  typedef logic [1:0]  wdt_psc_t;

  // bus handshake states, one-hot
  typedef enum logic [1:0] {
    WDT_BUS_IDLE = 2'b01,
    WDT_BUS_DONE = 2'b10
  } wdt_bus_e;
endpackage

// file: wdt_presc.sv
`include "wdt_cfg.svh"

module wdt_presc (
  // clock and reset
  input  logic              clk,
  input  logic              rst_n,
  // oscillator level and divider select
  input  logic              osc,
  input  wdt_pkg::wdt_psc_t sel,
  // one-cycle divided tick
  output logic              tick
);
  import wdt_pkg::*;

  logic       osc_q;  // previous oscillator level
  logic [7:0] div_q;  // free running edge count
  logic       rise;   // oscillator rising edge
  logic       hit;    // divider terminal reached

  assign rise = osc & ~osc_q;

  // divider select; reserved code falls back to divide by one
  always_comb begin
    if (sel == `WDT_PSC_DIV16) begin
      hit = (div_q[3:0] == `WDT_PSC_M16);
    end else if (sel == `WDT_PSC_DIV256) begin
      hit = (div_q == `WDT_PSC_M256); // RL8
    end else begin
      hit = 1'b1;
    end
  end

  // edge detector and edge counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_q <= 1'b0;
      div_q <= `WDT_PSC_RST;
    end else begin
      osc_q <= osc;
      if (rise) begin
        div_q <= div_q + `WDT_PSC_STEP; // RL3
      end
    end
  end

  // registered tick, one per selected number of oscillator edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= rise & hit; // RL3
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_div1_tick;
    (sel == `WDT_PSC_DIV1) && rise |=> tick;
  endproperty
  a_div1_tick: assert property (p_div1_tick) else $error("divide by one missed a tick"); // RL3
endmodule

// file: wdt_top.sv
`include "wdt_cfg.svh"

// Overview of operation
// RL1: offers normal timer mode and watchdog mode
// RL2: reload on overflow and on service write
// RL3: oscillator prescaled by one, sixteen or 256
// RL4: normal mode is a 16-bit timer
// RL5: capture count when interrupt enable bit set
// RL6: control bit five enters watchdog mode
// RL7: watchdog counts down from load to zero
// RL8: longest timeout is 512 seconds
// RL9: software keeps timeout at least 30 ms
// RL10: expiry gives reset or interrupt per bit1
// RL11: software services before the count expires
// RL12: watchdog locks load and control until power-on
// RL13: other resets leave watchdog counting
// RL14: counting pauses while debug halts the core
// RL15: runs in power-down unless bit0 set
// RL16: service write clears the timer interrupt
// RL17: count register reads current counter
// RL18: software sets watchdog up right after reset
// RL19: bit1 set gives interrupt instead of reset
// RL20: control bit eight selects count up
// RL21: control bit six selects periodic mode
// RL22: normal mode counts only when enabled
module wdt_top (
  // system clock and power-on reset
  input  logic               CLK_SYS,
  input  logic               RST_N,
  // avalon-mm slave
  input  wdt_pkg::wdt_data_t AVS_ADDRESS,
  input  logic               AVS_READ,
  input  logic               AVS_WRITE,
  input  wdt_pkg::wdt_data_t AVS_WRITEDATA,
  input  wdt_pkg::wdt_be_t   AVS_BYTEENABLE,
  output wdt_pkg::wdt_data_t AVS_READDATA,
  output logic               AVS_WAITREQUEST,
  // timebase and system status
  input  logic               OSC_32K,
  input  logic               DBG_HALT,
  input  logic               POWER_DOWN,
  input  logic               SYS_RESET,
  input  logic               INT_EN_CAPTURE,
  input  logic               CAPTURE_EVENT,
  // events
  output logic               CHIP_RESET,
  output logic               TMR_IRQ
);
  import wdt_pkg::*;

  wdt_bus_e  bus_q;     // bus handshake state
  wdt_data_t rdata_q;   // registered read data
  wdt_word_t load_q;    // timeout_load
  wdt_word_t count_q;   // current_count
  wdt_word_t ctrl_q;    // wdog_control
  wdt_word_t cap_q;     // captured count
  wdt_word_t count_d;   // next counter value
  wdt_word_t rd_mux;    // read selection
  logic      irq_q;     // timer interrupt flag
  logic      rst_q;     // chip reset pulse
  logic      tick;      // prescaled tick
  logic      sel_load;  // address decode strobes
  logic      sel_count;
  logic      sel_ctrl;
  logic      sel_svc;
  logic      sel_cap;
  logic      wr_fire;   // write taken this edge
  logic      svc_wr;    // service_clear written
  logic      load_wr;   // load accepted
  logic      ctrl_wr;   // control accepted
  logic      wdog;      // watchdog mode, also the write lock
  logic      soft_clr;  // non power-on reset outside watchdog mode
  logic      run;       // counter steps this cycle
  logic      down;      // count direction
  logic      term;      // counter at its end point
  logic      expire;    // end point reached on a step

  // merge written byte lanes into a 16-bit register
  function automatic wdt_word_t wmerge(input wdt_word_t old, input wdt_data_t d, input wdt_be_t be);
    wdt_word_t r;
    r = old;
    if (be[0]) begin
      r[7:0] = d[7:0];
    end
    if (be[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  // prescaler from the slow oscillator
  wdt_presc u_presc (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .osc   (OSC_32K),
    .sel   (ctrl_q[`WDT_B_PSC_HI:`WDT_B_PSC_LO]),
    .tick  (tick)
  );

  // address decode, full 32-bit compare
  always_comb begin
    sel_load  = 1'b0;
    sel_count = 1'b0;
    sel_ctrl  = 1'b0;
    sel_svc   = 1'b0;
    sel_cap   = 1'b0;
    if (AVS_ADDRESS == `WDT_ADDR_LOAD) begin
      sel_load = 1'b1;
    end else if (AVS_ADDRESS == `WDT_ADDR_COUNT) begin
      sel_count = 1'b1;
    end else if (AVS_ADDRESS == `WDT_ADDR_CTRL) begin
      sel_ctrl = 1'b1;
    end else if (AVS_ADDRESS == `WDT_ADDR_SVC) begin
      sel_svc = 1'b1;
    end else if (AVS_ADDRESS == `WDT_ADDR_CAP) begin
      sel_cap = 1'b1;
    end
  end

  // read mux; write-only and unmapped words read as zero
  always_comb begin
    if (sel_load) begin
      rd_mux = load_q;
    end else if (sel_count) begin
      rd_mux = count_q; // RL17
    end else if (sel_ctrl) begin
      rd_mux = ctrl_q;
    end else if (sel_cap) begin
      rd_mux = cap_q;
    end else begin
      rd_mux = `WDT_CNT_ZERO;
    end
  end

  // every access waits exactly one cycle, keeping decode off the answer path
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & (bus_q != WDT_BUS_DONE);
  assign wr_fire         = AVS_WRITE & (bus_q == WDT_BUS_DONE);
  assign svc_wr          = wr_fire & sel_svc; // RL2
  assign load_wr         = wr_fire & sel_load & ~wdog; // RL12
  assign ctrl_wr         = wr_fire & sel_ctrl & ~wdog; // RL12
  assign AVS_READDATA    = rdata_q;
  assign CHIP_RESET      = rst_q;
  assign TMR_IRQ         = irq_q;

  // bus handshake state machine
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      bus_q <= WDT_BUS_IDLE;
    end else begin
      case (bus_q)
        WDT_BUS_IDLE: begin
          if (AVS_READ | AVS_WRITE) begin
            bus_q <= WDT_BUS_DONE;
          end
        end
        WDT_BUS_DONE: begin
          bus_q <= WDT_BUS_IDLE;
        end
        default: begin
          bus_q <= WDT_BUS_IDLE;
        end
      endcase
    end
  end

  // read data captured on the first edge, held through the answer edge
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= `WDT_RDATA_RST;
    end else if (AVS_READ && (bus_q == WDT_BUS_IDLE)) begin
      rdata_q <= {`WDT_HI_ZERO, rd_mux};
    end
  end

  // mode and lock: watchdog bit is the lock, only power-on clears it
  assign wdog     = ctrl_q[`WDT_B_WDOG]; // RL1 RL6
  assign soft_clr = SYS_RESET & ~wdog; // RL13

  // counting conditions
  assign run    = tick & ~DBG_HALT // RL14
                & ~(POWER_DOWN & ctrl_q[`WDT_B_PDOFF]) // RL15
                & (wdog | ctrl_q[`WDT_B_EN]); // RL22
  assign down   = wdog | ~ctrl_q[`WDT_B_UP]; // RL7 RL20
  assign term   = down ? (count_q == `WDT_CNT_ZERO) : (count_q == `WDT_CNT_MAX);
  assign expire = run & term;

  // control register
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= `WDT_CTRL_RST;
    end else if (soft_clr) begin
      ctrl_q <= `WDT_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= wmerge(ctrl_q, AVS_WRITEDATA, AVS_BYTEENABLE) & `WDT_CTRL_MASK; // RL6
    end
  end

  // load register; writing it does not touch the running count
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      load_q <= `WDT_LOAD_RST;
    end else if (soft_clr) begin
      load_q <= `WDT_LOAD_RST;
    end else if (load_wr) begin
      load_q <= wmerge(load_q, AVS_WRITEDATA, AVS_BYTEENABLE); // RL4
    end
  end

  // next count; service write beats a same-cycle step
  always_comb begin
    count_d = count_q;
    if (soft_clr) begin
      count_d = `WDT_COUNT_RST;
    end else if (svc_wr) begin
      count_d = load_q; // RL2
    end else if (run) begin
      if (term) begin
        if (wdog || ctrl_q[`WDT_B_PERIODIC]) begin
          count_d = load_q; // RL2 RL21
        end else if (down) begin
          count_d = `WDT_CNT_MAX;
        end else begin
          count_d = `WDT_CNT_ZERO;
        end
      end else if (down) begin
        count_d = count_q - `WDT_CNT_STEP; // RL7
      end else begin
        count_d = count_q + `WDT_CNT_STEP; // RL4 RL20
      end
    end
  end

  // counter register
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      count_q <= `WDT_COUNT_RST;
    end else begin
      count_q <= count_d;
    end
  end

  // interrupt flag: a new event wins over a clear in the same cycle
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      irq_q <= 1'b0;
    end else if (expire && (!wdog || ctrl_q[`WDT_B_IRQSEL])) begin
      irq_q <= 1'b1; // RL19
    end else if (svc_wr || soft_clr) begin
      irq_q <= 1'b0; // RL16
    end
  end

  // chip reset request, one cycle per expiry
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_q <= 1'b0;
    end else begin
      rst_q <= expire & wdog & ~ctrl_q[`WDT_B_IRQSEL]; // RL10
    end
  end

  // capture of the running count in normal mode
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cap_q <= `WDT_CAP_RST;
    end else if (CAPTURE_EVENT && INT_EN_CAPTURE && !wdog) begin
      cap_q <= count_q; // RL5
    end
  end

  // sequences for multi-step checks
  sequence s_wd_expire;
    wdog && run && (count_q == `WDT_CNT_ZERO) && !ctrl_q[`WDT_B_IRQSEL];
  endsequence

  sequence s_rd_count;
    AVS_READ && sel_count && (bus_q == WDT_BUS_IDLE) ##1 AVS_READ && !AVS_WAITREQUEST;
  endsequence

  property p_svc_reload;
    svc_wr && !soft_clr |=> count_q == $past(load_q);
  endproperty
  a_svc_reload: assert property (p_svc_reload) else $error("service write did not reload"); // RL2

  property p_wd_dec;
    wdog && run && !term && !svc_wr |=> count_q == $past(count_q) - `WDT_CNT_STEP;
  endproperty
  a_wd_dec: assert property (p_wd_dec) else $error("watchdog did not count down"); // RL7

  property p_wd_reset;
    (s_wd_expire and !svc_wr) |=> CHIP_RESET ##1 !CHIP_RESET;
  endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("expiry reset pulse wrong"); // RL10

  property p_wd_irq;
    expire && wdog && ctrl_q[`WDT_B_IRQSEL] |=> TMR_IRQ && !CHIP_RESET;
  endproperty
  a_wd_irq: assert property (p_wd_irq) else $error("expiry interrupt wrong"); // RL19

  property p_lock;
    wdog |=> $stable(ctrl_q) && $stable(load_q);
  endproperty
  a_lock: assert property (p_lock) else $error("locked register changed"); // RL12

  property p_soft_keep;
    SYS_RESET && wdog && !svc_wr && !run |=> $stable(count_q) && wdog;
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("other reset disturbed watchdog"); // RL13

  property p_halt;
    DBG_HALT && !svc_wr && !soft_clr |=> $stable(count_q);
  endproperty
  a_halt: assert property (p_halt) else $error("count moved during debug halt"); // RL14

  property p_pd;
    POWER_DOWN && ctrl_q[`WDT_B_PDOFF] && !svc_wr && !soft_clr |=> $stable(count_q);
  endproperty
  a_pd: assert property (p_pd) else $error("count moved in power-down"); // RL15

  property p_svc_irq;
    svc_wr && !expire |=> !TMR_IRQ;
  endproperty
  a_svc_irq: assert property (p_svc_irq) else $error("service write left interrupt set"); // RL16

  property p_read_count;
    s_rd_count |-> AVS_READDATA == {`WDT_HI_ZERO, $past(count_q)};
  endproperty
  a_read_count: assert property (p_read_count) else $error("count read mismatch"); // RL17

  property p_disabled;
    !wdog && !ctrl_q[`WDT_B_EN] && !svc_wr && !soft_clr |=> $stable(count_q);
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled timer counted"); // RL22

  property p_capture;
    CAPTURE_EVENT && INT_EN_CAPTURE && !wdog |=> cap_q == $past(count_q);
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed"); // RL5

  property p_up;
    !wdog && run && ctrl_q[`WDT_B_UP] && !term && !svc_wr && !soft_clr |=> count_q == $past(count_q) + `WDT_CNT_STEP;
  endproperty
  a_up: assert property (p_up) else $error("up count wrong"); // RL20

  property p_periodic;
    !wdog && run && term && ctrl_q[`WDT_B_PERIODIC] && !svc_wr && !soft_clr |=> count_q == $past(load_q);
  endproperty
  a_periodic: assert property (p_periodic) else $error("periodic reload wrong"); // RL21
endmodule

// file: wdt_top_tb.sv
`include "wdt_cfg.svh"

module wdt_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import wdt_pkg::*;

  logic      clk_sys;       // 20 MHz system clock
  logic      rst_n;         // power-on reset, active low
  wdt_data_t address;       // bus address
  logic      rd;            // read request
  logic      wr;            // write request
  wdt_data_t wdata;         // write data
  wdt_be_t   be;            // byte lanes
  wdt_data_t rdata;         // read data
  logic      waitreq;       // slave stall
  logic      osc;           // slow oscillator level
  logic      dbg_halt;      // debug hold
  logic      pwr_down;      // power-down status
  logic      sys_rst;       // non power-on reset
  logic      cap_en;        // capture interrupt enable
  logic      cap_ev;        // capture event pulse
  logic      chip_rst;      // expiry reset pulse
  logic      irq;           // timer interrupt
  int        errors;        // mismatches seen
  int        check_count;   // comparisons made
  int        pulses;        // expiry reset pulses seen
  wdt_data_t v;             // last read value

  wdt_top u_dut (
    .CLK_SYS        (clk_sys),
    .RST_N          (rst_n),
    .AVS_ADDRESS    (address),
    .AVS_READ       (rd),
    .AVS_WRITE      (wr),
    .AVS_WRITEDATA  (wdata),
    .AVS_BYTEENABLE (be),
    .AVS_READDATA   (rdata),
    .AVS_WAITREQUEST(waitreq),
    .OSC_32K        (osc),
    .DBG_HALT       (dbg_halt),
    .POWER_DOWN     (pwr_down),
    .SYS_RESET      (sys_rst),
    .INT_EN_CAPTURE (cap_en),
    .CAPTURE_EVENT  (cap_ev),
    .CHIP_RESET     (chip_rst),
    .TMR_IRQ        (irq)
  );

  // free-running clock, 50 ns period
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // count expiry pulses; a one-cycle pulse is easy to miss by polling
  always @(posedge clk_sys) begin
    if (chip_rst === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  // compare one value and report at once
  task automatic check(input wdt_data_t seen, input wdt_data_t exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // hold the request until waitrequest is seen low at a rising edge
  task automatic bus_wait();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitreq !== 1'b0 && n < 100);
    if (n >= 100) begin
      errors++;
      $display("MISMATCH t=%0t bus access never completed", $time);
    end
  endtask

  task automatic bus_write(input wdt_data_t a, input wdt_data_t d, input wdt_be_t b);
    @(posedge clk_sys);
    address <= a;
    wdata   <= d;
    be      <= b;
    wr      <= 1'b1;
    bus_wait();
    wr      <= 1'b0;
  endtask

  // read data is taken at the same edge that ends the wait
  task automatic bus_read(input wdt_data_t a, output wdt_data_t d);
    @(posedge clk_sys);
    address <= a;
    rd      <= 1'b1;
    bus_wait();
    d = rdata;
    rd      <= 1'b0;
  endtask

  task automatic expect_reg(input wdt_data_t a, input wdt_data_t exp);
    wdt_data_t d;
    bus_read(a, d);
    check(d, exp);
  endtask

  // one oscillator period; the divided tick and its step land inside it
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      osc <= 1'b1;
      repeat (2) @(posedge clk_sys);
      osc <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask

  task automatic power_on();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // the tests need a few thousand cycles; this span leaves ample margin
  initial begin
    #(50 * 60000);
    errors++;
    complete_run();
  end

  initial begin
    // pulses is only written by its counting process and starts at zero
    rst_n = 1'b0;
    address = '0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = '0;
    be = '0;
    osc = 1'b0;
    dbg_halt = 1'b0;
    pwr_down = 1'b0;
    sys_rst = 1'b0;
    cap_en = 1'b0;
    cap_ev = 1'b0;
    errors = 0;
    check_count = 0;
    power_on();
    // reset values, write-only and unmapped places
    // default load of 983 ticks at divide by one keeps the timeout near 30 ms
    expect_reg(`WDT_ADDR_LOAD, 32'h000003D7);
    expect_reg(`WDT_ADDR_COUNT, 32'h000003D7);
    expect_reg(`WDT_ADDR_CTRL, 32'h00000000);
    expect_reg(`WDT_ADDR_SVC, 32'h00000000);
    bus_write(32'hFFFF0374, 32'h0000ABCD, 4'hF);
    expect_reg(32'hFFFF0374, 32'h00000000);
    // byte lanes, then read-only count ignores writes
    bus_write(`WDT_ADDR_LOAD, 32'h0000ABCD, 4'h1);
    expect_reg(`WDT_ADDR_LOAD, 32'h000003CD);
    bus_write(`WDT_ADDR_COUNT, 32'h00001234, 4'hF);
    expect_reg(`WDT_ADDR_COUNT, 32'h000003D7);
    // service write reloads at once; enabled down count steps per tick
    bus_write(`WDT_ADDR_LOAD, 32'h00000005, 4'hF);
    bus_write(`WDT_ADDR_CTRL, 32'h00000080, 4'hF);
    bus_write(`WDT_ADDR_SVC, 32'h00000000, 4'h2);
    expect_reg(`WDT_ADDR_COUNT, 32'h00000005);
    ticks(3);
    expect_reg(`WDT_ADDR_COUNT, 32'h00000002);
    // debug hold freezes, power-down only with the stop bit
    dbg_halt <= 1'b1;
    ticks(2);
    expect_reg(`WDT_ADDR_COUNT, 32'h00000002);
    dbg_halt <= 1'b0;
    pwr_down <= 1'b1;
    ticks(1);
    expect_reg(`WDT_ADDR_COUNT, 32'h00000001);
    bus_write(`WDT_ADDR_CTRL, 32'h00000081, 4'hF);
    ticks(2);
    expect_reg(`WDT_ADDR_COUNT, 32'h00000001);
    pwr_down <= 1'b0;
    // disabled timer holds its count
    bus_write(`WDT_ADDR_CTRL, 32'h00000000, 4'hF);
    ticks(2);
    expect_reg(`WDT_ADDR_COUNT, 32'h00000001);
    // count up
    bus_write(`WDT_ADDR_CTRL, 32'h00000180, 4'hF);
    bus_write(`WDT_ADDR_SVC, 32'h00000000, 4'hF);
    ticks(3);
    expect_reg(`WDT_ADDR_COUNT, 32'h00000008);
    // prescaler phase is free-running, so whole periods are counted
    bus_write(`WDT_ADDR_CTRL, 32'h00000084, 4'hF);
    bus_write(`WDT_ADDR_SVC, 32'h00000000, 4'hF);
    ticks(32);
    expect_reg(`WDT_ADDR_COUNT, 32'h00000003);
    bus_write(`WDT_ADDR_CTRL, 32'h00000088, 4'hF);
    bus_write(`WDT_ADDR_SVC, 32'h00000000, 4'hF);
    ticks(256);
    expect_reg(`WDT_ADDR_COUNT, 32'h00000004);
    // capture only while the enable level is high
    bus_write(`WDT_ADDR_CTRL, 32'h00000000, 4'hF);
    cap_en <= 1'b1;
    @(posedge clk_sys) cap_ev <= 1'b1;
    @(posedge clk_sys) cap_ev <= 1'b0;
    expect_reg(`WDT_ADDR_CAP, 32'h00000004);
    cap_en <= 1'b0;
    bus_write(`WDT_ADDR_SVC, 32'h00000000, 4'hF);
    @(posedge clk_sys) cap_ev <= 1'b1;
    @(posedge clk_sys) cap_ev <= 1'b0;
    expect_reg(`WDT_ADDR_CAP, 32'h00000004);
    // periodic stays within the load value, free-running wraps below zero
    bus_write(`WDT_ADDR_LOAD, 32'h00000002, 4'hF);
    bus_write(`WDT_ADDR_CTRL, 32'h000000C0, 4'hF);
    bus_write(`WDT_ADDR_SVC, 32'h00000000, 4'hF);
    ticks(5);
    check({31'h0, irq}, 32'h00000001);
    bus_read(`WDT_ADDR_COUNT, v);
    check({31'h0, v <= 32'h2}, 32'h00000001);
    bus_write(`WDT_ADDR_SVC, 32'h00000055, 4'hF);
    @(posedge clk_sys);
    check({31'h0, irq}, 32'h00000000);
    bus_write(`WDT_ADDR_CTRL, 32'h00000080, 4'hF);
    ticks(5);
    bus_read(`WDT_ADDR_COUNT, v);
    check({31'h0, v > 32'h2}, 32'h00000001);
    // other reset in normal mode restores defaults
    @(posedge clk_sys) sys_rst <= 1'b1;
    @(posedge clk_sys) sys_rst <= 1'b0;
    expect_reg(`WDT_ADDR_LOAD, 32'h000003D7);
    expect_reg(`WDT_ADDR_CTRL, 32'h00000000);
    // watchdog with interrupt on expiry; load and control lock
    bus_write(`WDT_ADDR_LOAD, 32'h00000003, 4'hF);
    bus_write(`WDT_ADDR_CTRL, 32'h00000022, 4'hF);
    bus_write(`WDT_ADDR_SVC, 32'h00000000, 4'hF);
    bus_write(`WDT_ADDR_LOAD, 32'h00000009, 4'hF);
    bus_write(`WDT_ADDR_CTRL, 32'h00000000, 4'hF);
    expect_reg(`WDT_ADDR_LOAD, 32'h00000003);
    expect_reg(`WDT_ADDR_CTRL, 32'h00000022);
    ticks(3);
    expect_reg(`WDT_ADDR_COUNT, 32'h00000000);
    check({31'h0, irq}, 32'h00000000);
    ticks(1);
    check({31'h0, irq}, 32'h00000001);
    check(pulses, 0);
    // servicing reloads and clears; other reset leaves it counting
    bus_write(`WDT_ADDR_SVC, 32'h000000A5, 4'hF);
    expect_reg(`WDT_ADDR_COUNT, 32'h00000003);
    check({31'h0, irq}, 32'h00000000);
    @(posedge clk_sys) sys_rst <= 1'b1;
    @(posedge clk_sys) sys_rst <= 1'b0;
    ticks(1);
    expect_reg(`WDT_ADDR_CTRL, 32'h00000022);
    expect_reg(`WDT_ADDR_COUNT, 32'h00000002);
    // power-on reset frees the registers; expiry then pulses reset
    power_on();
    expect_reg(`WDT_ADDR_CTRL, 32'h00000000);
    bus_write(`WDT_ADDR_LOAD, 32'h00000002, 4'hF);
    bus_write(`WDT_ADDR_CTRL, 32'h00000020, 4'hF);
    bus_write(`WDT_ADDR_SVC, 32'h00000000, 4'hF);
    ticks(2);
    check(pulses, 0);
    ticks(1);
    check(pulses, 1);
    check({31'h0, irq}, 32'h00000000);
    complete_run();
  end
endmodule
